// *** dv/crb_checker.sv ***
`timescale 1ns/1ns
module crb_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic asm_valid,
   input wire logic asm_error,
   input wire logic rx_timestamp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence joint_write;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence read_taken;
      arvalid && arready;
   endsequence
   ts_width_a: assert property (rx_timestamp && !(asm_valid || asm_error) |=> !rx_timestamp)
      else $error("time-stamp pulse too long");
   ts_cause_a: assert property (rx_timestamp |-> $past(asm_valid || asm_error))
      else $error("time-stamp pulse without message");
   write_answer_a: assert property (joint_write |=> !bvalid ##1 bvalid)
      else $error("write response late or early");
   write_busy_a: assert property (joint_write |=> !awready && !wready)
      else $error("write channel ready while busy");
   read_answer_a: assert property (read_taken |=> rvalid)
      else $error("read data late");
   read_busy_a: assert property (rvalid |-> !arready)
      else $error("read address ready while data pending");
   bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped or changed");
endmodule

bind crb_receive_buffer_manager crb_checker u_chk (.*);

// *** dv/crb_engine_model.sv ***
`timescale 1ns/1ns
module crb_engine_model (
   input wire logic aclk,
   output logic asm_valid,
   output logic asm_error,
   output logic asm_ext,
   output logic asm_rtr,
   output logic [7:0] asm_std_id_high,
   output logic [7:0] asm_std_id_low,
   output logic [7:0] asm_ext_id_high,
   output logic [7:0] asm_ext_id_low,
   output logic [3:0] asm_dlc,
   output logic [63:0] asm_data,
   output logic [15:0] filter_match
);
   initial begin
      {asm_valid, asm_error, asm_ext, asm_rtr, filter_match, asm_data} = '0;
      {asm_std_id_high, asm_std_id_low, asm_ext_id_high, asm_ext_id_low, asm_dlc} = '0;
   end
   task automatic send(input logic e, input logic r, input logic er, input logic [15:0] fm,
                       input logic [63:0] d);
      @(posedge aclk);
      {asm_valid, asm_error} <= {!er, er};
      {asm_ext, asm_rtr, filter_match, asm_data} <= {e, r, fm, d};
      {asm_std_id_high, asm_std_id_low, asm_ext_id_high, asm_ext_id_low, asm_dlc} <= 36'ha5083c5a8;
      @(posedge aclk);
      {asm_valid, asm_error} <= 2'h0;
      // Released lines flip so a stale image never looks valid
      {asm_ext, asm_rtr, filter_match, asm_data} <= ~{e, r, fm, d};
      {asm_std_id_high, asm_std_id_low, asm_ext_id_high, asm_ext_id_low, asm_dlc} <= ~36'ha5083c5a8;
   endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ns
module tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, rx_irq, fifo_watermark_irq, rx_timestamp, asm_valid, asm_error;
   logic asm_ext, asm_rtr;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, asm_dlc;
   logic [1:0] bresp, rresp;
   logic [7:0] asm_std_id_high, asm_std_id_low, asm_ext_id_high, asm_ext_id_low;
   logic [63:0] asm_data, filter_buffer, rnd;
   logic [15:0] filter_match, filter_enable, filter_extended_select, mask_extended_select;
   logic [45:0] q[$];
   logic [45:0] note;
   logic [31:0] ex [1:3];
   int n_mismatch, n_tests, n_ts, i;
   crb_receive_buffer_manager uut (.*);
   crb_engine_model eng (.*);
   always #25 aclk = ~aclk;
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      q.push_back({a, r, 32'h0});
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hf};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      q.push_back({a, r, e});
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (rx_timestamp === 1'b1) n_ts++;
      if ((rvalid && rready) || (bvalid && bready)) begin
         note = q.pop_front();
         chk($sformatf("reg %h", note[45:34]), rvalid ? {rresp, rdata} : {bresp, 32'h0}, note[33:0]);
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      print_verdict;
   end
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata, wstrb, filter_enable, mask_extended_select} = '0;
      filter_extended_select = 16'h0005;
      filter_buffer = 64'hffff_ffff_6455_ffff;
      ex = '{32'h620, 32'h2c0, 32'he0};
      void'($urandom(32'hcdd5));
      rnd = {$urandom, $urandom};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, 32'h0);
      rd(12'h10c, 32'h0);
      rd(12'h200, 32'h0, 2'h2);
      wr(12'h200, 32'h0, 2'h2);
      wr(12'h014, 32'h0, 2'h2);
      wr(12'h110, 32'h1);
      wr(12'h000, 32'h4);
      eng.send(1'b0, 1'b1, 1'b0, 16'h0002, rnd);
      rd(12'h000, 32'h194);
      rd(12'h004, 32'ha5003c5a);
      rd(12'h008, 32'h8);
      rd(12'h00c, rnd[31:0]);
      chk("rx_irq", 34'(rx_irq), 34'h1);
      eng.send(1'b1, 1'b0, 1'b0, 16'h0001, ~rnd);
      rd(12'h000, 32'h194);
      wr(12'h000, 32'h8c);
      eng.send(1'b1, 1'b0, 1'b0, 16'h0001, ~rnd);
      rd(12'h020, 32'h680);
      rd(12'h024, 32'ha5083c5a);
      rd(12'h030, ~rnd[63:32]);
      wr(12'h000, 32'h0);
      repeat (2) @(negedge aclk);
      chk("rx_irq", 34'(rx_irq), 34'h0);
      // Mode 1 must refuse the extended frame, mode 3 takes the aborted one
      for (i = 1; i < 4; i++) begin
         wr(12'h020, 32'(i) << 5);
         eng.send(1'b1, 1'b0, i == 3, (i < 3) ? 16'h0004 : 16'h0, rnd);
         rd(12'h020, ex[i]);
      end
      wr(12'h020, 32'h0);
      filter_enable <= 16'hffff;
      wr(12'h10c, 32'h4);
      wr(12'h108, 32'he0);
      repeat (3) eng.send(1'b1, 1'b0, 1'b0, 16'h0800, rnd);
      repeat (2) @(negedge aclk);
      chk("wm_irq", 34'(fifo_watermark_irq), 34'h1);
      rd(12'h104, 32'h10);
      rd(12'h100, 32'h0);
      rd(12'h040, 32'hb80);
      wr(12'h000, 32'h0);
      rd(12'h100, 32'h1);
      repeat (2) eng.send(1'b1, 1'b0, 1'b0, 16'h0800, rnd);
      rd(12'h060, 32'hb80);
      rd(12'h080, 32'h0);
      rd(12'h000, 32'hb80);
      wr(12'h108, 32'h40);
      mask_extended_select <= 16'h0020;
      eng.send(1'b1, 1'b0, 1'b0, 16'h0020, rnd);
      rd(12'h0a0, 32'h0);
      mask_extended_select <= 16'h0;
      eng.send(1'b1, 1'b0, 1'b0, 16'h0060, rnd);
      rd(12'h0a0, 32'h0);
      eng.send(1'b1, 1'b0, 1'b0, 16'h00a0, rnd);
      rd(12'h0a0, 32'h580);
      wr(12'h110, 32'h0);
      eng.send(1'b1, 1'b0, 1'b0, 16'h0080, rnd);
      rd(12'h0c0, 32'h780);
      chk("ts_count", 34'(n_ts), 34'd10);
      print_verdict;
   end
endmodule

// *** logic/crb_pkg.sv ***
package crb_pkg;
   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NUM_BUF = 8;
   localparam int NUM_FILT = 16;
   localparam int NUM_PROG = 6;
   localparam int NUM_DEDICATED = 2;
   localparam int LEGACY_FILT = 6;
   localparam int LEGACY_FIRST_FILT = 2;

   // ----------------------------------------------------------------------
   // Register map (byte addresses of module registers, word indices of buffer registers)
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFS_MODULE_CONTROL = 12'h100;
   localparam logic [11:0] OFS_MODULE_STATUS = 12'h104;
   localparam logic [11:0] OFS_ENHANCED_CONTROL = 12'h108;
   localparam logic [11:0] OFS_BUFFER_SELECT = 12'h10c;
   localparam logic [11:0] OFS_TIMESTAMP_CONTROL = 12'h110;
   localparam logic [2:0] BREG_CONTROL = 3'h0;
   localparam logic [2:0] BREG_ID = 3'h1;
   localparam logic [2:0] BREG_DLC = 3'h2;
   localparam logic [2:0] BREG_DATA_LO = 3'h3;
   localparam logic [2:0] BREG_DATA_HI = 3'h4;

   // ----------------------------------------------------------------------
   // Buffer control, id and enhanced control field positions
   // ----------------------------------------------------------------------
   localparam int CTL_IE = 2;
   localparam int CTL_ROLL = 3;
   localparam int CTL_RTR = 4;
   localparam int CTL_MODE_LO = 5;
   localparam int CTL_RXALL = 6;
   localparam int CTL_FULL = 7;
   localparam int CTL_HIT_LO = 8;
   localparam int ID_EXT_FLAG = 19;
   localparam int ENH_WM = 5;
   localparam int ENH_MODE_LO = 6;

   // ----------------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------------
   localparam logic [1:0] RXM_ALL_VALID = 2'h0;
   localparam logic [1:0] RXM_STD_ONLY = 2'h1;
   localparam logic [1:0] RXM_EXT_ONLY = 2'h2;
   localparam logic [1:0] RXM_RECEIVE_ALL = 2'h3;
   localparam logic [4:0] ICODE_FIFO = 5'h10;
   localparam logic [4:0] ICODE_BUF_BASE = 5'h08;
   localparam logic [4:0] ROLL_HIT_BASE = 5'h06;
   localparam logic [3:0] FIFO_BASE_LEN = 4'h2;
   localparam logic [3:0] WM_ONE_EMPTY = 4'h1;
   localparam logic [3:0] WM_FOUR_EMPTY = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CRB_LEGACY = 2'h0,
      CRB_ENHANCED = 2'h1,
      CRB_FIFO = 2'h3
   } crb_mode_type;

   typedef struct packed {
      logic [NUM_BUF-1:0][12:0] ctl;
      logic [NUM_BUF-1:0][31:0] id;
      logic [NUM_BUF-1:0][3:0] dlc;
      logic [NUM_BUF-1:0][63:0] data;
      crb_mode_type mode;
      logic [2:0] wp;
      logic [2:0] rp;
      logic wm;
      logic [NUM_PROG-1:0] txen;
      logic ts_en;
      logic [4:0] icode;
      logic aw_have;
      logic [11:0] aw_addr;
      logic w_have;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rx_irq;
      logic wm_irq;
      logic ts_pulse;
   } crb_state_type;
endpackage

// *** logic/crb_receive_buffer_manager.sv ***
// Operation
// - An accepted message overwrites id, dlc, data and the full, remote and filter fields of the target buffer's control.
// - Loading sets the full flag; firmware clears it after processing.
// - A buffer whose full flag is set is never loaded.
// - Receive interrupt raised when a loaded buffer has its interrupt enable set.
// - Filter number recorded in buffer control, 3 bits legacy, 5 bits otherwise.
// - Buffer control shows whether the message is a remote request frame.
// - Extended flag in the low standard id byte follows the identifier type.
// - Mode 00 accepts filter-passing messages; filter extended bit picks type.
// - Legacy modes 01/10 accept standard/extended only; contradicting filters never hit.
// - Enhanced modes: mask extended bit restricts reception to one identifier type.
// - Receive-all takes every message and loads partial frames on error.
// - Enhanced and FIFO modes discard messages hitting a filter tied to a transmit buffer unless a receive-all buffer takes them.
// - Legacy: first buffer filters 0-1 high priority, second filters 2-5.
// - Rollover puts messages for a full first buffer into the second.
// - Enhanced: any of 16 filters per buffer; lowest buffer number wins.
// - FIFO spans dedicated buffers up to the first transmit buffer, max eight.
// - FIFO: any enabled filter accepts; store at write pointer then advance.
// - FIFO reception reports interrupt code 10000 in the status register.
// - Read pointer names oldest unread buffer; advances when its flag clears.
// - Watermark selects early warning at one or four empty buffers.
// - Time-stamp pulse emitted per received message when enabled.
// - All programmable buffers reset as receive; transmit only via select bits.
`timescale 1ns/1ns
module crb_receive_buffer_manager (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic asm_valid,
   input wire logic asm_error,
   input wire logic asm_ext,
   input wire logic asm_rtr,
   input wire logic [7:0] asm_std_id_high,
   input wire logic [7:0] asm_std_id_low,
   input wire logic [7:0] asm_ext_id_high,
   input wire logic [7:0] asm_ext_id_low,
   input wire logic [3:0] asm_dlc,
   input wire logic [63:0] asm_data,
   input wire logic [15:0] filter_match,
   input wire logic [15:0] filter_enable,
   input wire logic [15:0] filter_extended_select,
   input wire logic [15:0] mask_extended_select,
   input wire logic [63:0] filter_buffer,
   output logic rx_irq,
   output logic fifo_watermark_irq,
   output logic rx_timestamp
);
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [4:0] lowest_set(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   function automatic logic legacy_type_ok(input logic [1:0] receive_mode_field, input logic fext,
                                           input logic mext);
      logic ok;
      ok = (fext == mext);
      case (receive_mode_field)
         crb_pkg::RXM_STD_ONLY: ok = ok && !mext;
         crb_pkg::RXM_EXT_ONLY: ok = ok && mext;
         default: ok = ok;
      endcase
      return ok;
   endfunction

   function automatic logic [2:0] ptr_next(input logic [2:0] p, input logic [3:0] len);
      logic [2:0] r;
      r = ({1'b0, p} == len - 4'h1) ? 3'h0 : 3'(p + 3'h1);
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   crb_pkg::crb_state_type st;
   crb_pkg::crb_state_type next_st;

   logic [3:0] flen;
   logic flen_stop;
   logic [15:0] fmatch;
   logic [15:0] enh_v;
   logic [5:0] leg_v;
   logic [7:0][15:0] buf_hits;
   logic [7:0] is_rx;
   logic [7:0] rx_all;
   logic tx_hit;
   logic msg_in;
   logic ld_go;
   logic [2:0] ld_buf;
   logic [4:0] ld_hit;
   logic cand;
   logic [2:0] cand_buf;
   logic a0;
   logic a1;
   logic [3:0] fifo_used;
   logic [3:0] nib;
   logic [3:0] wm_target;

   // ----------------------------------------------------------------------
   // Acceptance decision
   // ----------------------------------------------------------------------
   always_comb begin
      flen = crb_pkg::FIFO_BASE_LEN;
      flen_stop = 1'b0;
      for (int i = 0; i < crb_pkg::NUM_PROG; i++) begin
         if (!flen_stop && !st.txen[i]) begin
            flen = flen + 4'h1;
         end else begin
            flen_stop = 1'b1;
         end
      end
      // Reset leaves every select bit clear, so all buffers receive
      is_rx = {~st.txen, 2'h3};
      for (int b = 0; b < crb_pkg::NUM_BUF; b++) begin
         rx_all[b] = (st.mode == crb_pkg::CRB_LEGACY) ?
                     (st.ctl[b][6:5] == crb_pkg::RXM_RECEIVE_ALL) : st.ctl[b][crb_pkg::CTL_RXALL];
      end
      fmatch = filter_match & filter_enable;
      tx_hit = 1'b0;
      buf_hits = '0;
      for (int f = 0; f < crb_pkg::NUM_FILT; f++) begin
         nib = filter_buffer[f*4 +: 4];
         // Mask extended bit set: filter type must equal message type
         enh_v[f] = fmatch[f] &&
                    (!mask_extended_select[f] || (filter_extended_select[f] == asm_ext));
         if (enh_v[f] && nib < 4'(crb_pkg::NUM_BUF)) begin
            if (!is_rx[nib[2:0]]) begin
               tx_hit = 1'b1;
            end else begin
               buf_hits[nib[2:0]][f] = 1'b1;
            end
         end
      end
      for (int f = 0; f < crb_pkg::LEGACY_FILT; f++) begin
         leg_v[f] = filter_match[f] &&
                    legacy_type_ok((f < crb_pkg::LEGACY_FIRST_FILT) ? st.ctl[0][6:5] : st.ctl[1][6:5],
                                   filter_extended_select[f], asm_ext);
      end
      msg_in = asm_valid || asm_error;
      ld_go = 1'b0;
      ld_buf = 3'h0;
      ld_hit = 5'h00;
      cand = 1'b0;
      cand_buf = 3'h0;
      // Error frames pass only by receive-all; buffer 0's also lets them roll into buffer 1 or load the FIFO
      a0 = rx_all[0] || (asm_valid && |leg_v[1:0]);
      a1 = rx_all[1] || (asm_valid && |leg_v[5:2]);
      case (st.mode)
         crb_pkg::CRB_LEGACY: begin
            if (msg_in && a0 && !st.ctl[0][crb_pkg::CTL_FULL]) begin
               ld_go = 1'b1;
               ld_hit = lowest_set({14'h0000, leg_v[1:0]});
            end else if (msg_in && a0 && st.ctl[0][crb_pkg::CTL_ROLL] &&
                         !st.ctl[1][crb_pkg::CTL_FULL]) begin
               ld_go = 1'b1;
               ld_buf = 3'h1;
               ld_hit = crb_pkg::ROLL_HIT_BASE + lowest_set({14'h0000, leg_v[1:0]});
            end else if (msg_in && a1 && !st.ctl[1][crb_pkg::CTL_FULL]) begin
               ld_go = 1'b1;
               ld_buf = 3'h1;
               ld_hit = lowest_set({10'h000, leg_v[5:2], 2'h0});
            end
         end
         crb_pkg::CRB_ENHANCED: begin
            for (int b = crb_pkg::NUM_BUF - 1; b >= 0; b--) begin
               if (is_rx[b] && (rx_all[b] || (asm_valid && !tx_hit && |buf_hits[b]))) begin
                  cand = 1'b1;
                  cand_buf = 3'(b);
               end
            end
            if (msg_in && cand && !st.ctl[cand_buf][crb_pkg::CTL_FULL]) begin
               ld_go = 1'b1;
               ld_buf = cand_buf;
               ld_hit = lowest_set(buf_hits[cand_buf]);
            end
         end
         crb_pkg::CRB_FIFO: begin
            if (((asm_valid && !tx_hit && |enh_v) || (msg_in && rx_all[0])) &&
                !st.ctl[st.wp][crb_pkg::CTL_FULL]) begin
               ld_go = 1'b1;
               ld_buf = st.wp;
               ld_hit = lowest_set(enh_v);
            end
         end
         default: ld_go = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.ts_pulse = 1'b0;
      if (awvalid && st.awready) begin
         next_st.aw_have = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && st.wready) begin
         next_st.w_have = 1'b1;
         next_st.wdat = wdata;
         next_st.wstb = wstrb;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_have && st.w_have && !st.bvalid) begin
         next_st.aw_have = 1'b0;
         next_st.w_have = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = crb_pkg::RESP_OKAY;
         if (st.aw_addr < crb_pkg::OFS_MODULE_CONTROL) begin
            if (st.aw_addr[4:2] > crb_pkg::BREG_DATA_HI) begin
               next_st.bresp = crb_pkg::RESP_SLVERR;
            end else if (st.aw_addr[4:2] == crb_pkg::BREG_CONTROL && st.wstb[0]) begin
               next_st.ctl[st.aw_addr[7:5]][6:5] = st.wdat[6:5];
               next_st.ctl[st.aw_addr[7:5]][crb_pkg::CTL_IE] = st.wdat[crb_pkg::CTL_IE];
               if (st.aw_addr[7:5] == 3'h0) begin
                  next_st.ctl[0][crb_pkg::CTL_ROLL] = st.wdat[crb_pkg::CTL_ROLL];
               end
               // Only a zero write clears the flag; a one is ignored
               if (!st.wdat[crb_pkg::CTL_FULL] && st.ctl[st.aw_addr[7:5]][crb_pkg::CTL_FULL]) begin
                  next_st.ctl[st.aw_addr[7:5]][crb_pkg::CTL_FULL] = 1'b0;
                  if (st.mode == crb_pkg::CRB_FIFO && st.aw_addr[7:5] == st.rp) begin
                     next_st.rp = ptr_next(st.rp, flen);
                  end
               end
            end
         end else begin
            case (st.aw_addr)
               crb_pkg::OFS_ENHANCED_CONTROL: begin
                  if (st.wstb[0]) begin
                     next_st.mode = crb_pkg::crb_mode_type'(st.wdat[7:6]);
                     next_st.wm = st.wdat[crb_pkg::ENH_WM];
                     // Pointers restart so a mode change never leaves them past the end
                     next_st.wp = 3'h0;
                     next_st.rp = 3'h0;
                  end
               end
               crb_pkg::OFS_BUFFER_SELECT: begin
                  if (st.wstb[0]) begin
                     next_st.txen = st.wdat[5:0];
                  end
               end
               crb_pkg::OFS_TIMESTAMP_CONTROL: begin
                  if (st.wstb[0]) begin
                     next_st.ts_en = st.wdat[0];
                  end
               end
               crb_pkg::OFS_MODULE_CONTROL, crb_pkg::OFS_MODULE_STATUS: begin
                  next_st.bresp = crb_pkg::RESP_OKAY;
               end
               default: next_st.bresp = crb_pkg::RESP_SLVERR;
            endcase
         end
      end

      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = crb_pkg::RESP_OKAY;
         next_st.rdata = 32'h00000000;
         if (araddr < crb_pkg::OFS_MODULE_CONTROL) begin
            case (araddr[4:2])
               crb_pkg::BREG_CONTROL: next_st.rdata = {19'h0, st.ctl[araddr[7:5]]};
               crb_pkg::BREG_ID: next_st.rdata = st.id[araddr[7:5]];
               crb_pkg::BREG_DLC: next_st.rdata = {28'h0000000, st.dlc[araddr[7:5]]};
               crb_pkg::BREG_DATA_LO: next_st.rdata = st.data[araddr[7:5]][31:0];
               crb_pkg::BREG_DATA_HI: next_st.rdata = st.data[araddr[7:5]][63:32];
               default: next_st.rresp = crb_pkg::RESP_SLVERR;
            endcase
         end else begin
            case (araddr)
               crb_pkg::OFS_MODULE_CONTROL: next_st.rdata = {29'h0, st.rp};
               crb_pkg::OFS_MODULE_STATUS: next_st.rdata = {27'h0, st.icode};
               crb_pkg::OFS_ENHANCED_CONTROL: next_st.rdata = {24'h000000, st.mode, st.wm, 5'h00};
               crb_pkg::OFS_BUFFER_SELECT: next_st.rdata = {26'h0, st.txen};
               crb_pkg::OFS_TIMESTAMP_CONTROL: next_st.rdata = {31'h0, st.ts_en};
               default: next_st.rresp = crb_pkg::RESP_SLVERR;
            endcase
         end
      end

      // Load after firmware writes so a same-cycle set stands
      if (ld_go) begin
         next_st.id[ld_buf] = {asm_std_id_high, asm_std_id_low, asm_ext_id_high, asm_ext_id_low};
         next_st.id[ld_buf][crb_pkg::ID_EXT_FLAG] = asm_ext;
         next_st.dlc[ld_buf] = asm_dlc;
         next_st.data[ld_buf] = asm_data;
         next_st.ctl[ld_buf][crb_pkg::CTL_FULL] = 1'b1;
         next_st.ctl[ld_buf][crb_pkg::CTL_RTR] = asm_rtr;
         next_st.ctl[ld_buf][12:8] = (st.mode == crb_pkg::CRB_LEGACY) ?
                                     {2'h0, ld_hit[2:0]} : ld_hit;
         next_st.ts_pulse = st.ts_en;
         if (st.mode == crb_pkg::CRB_FIFO) begin
            next_st.icode = crb_pkg::ICODE_FIFO;
            next_st.wp = ptr_next(st.wp, flen);
         end else begin
            next_st.icode = crb_pkg::ICODE_BUF_BASE | {2'h0, ld_buf};
         end
      end

      next_st.rx_irq = 1'b0;
      fifo_used = 4'h0;
      for (int b = 0; b < crb_pkg::NUM_BUF; b++) begin
         if (next_st.ctl[b][crb_pkg::CTL_FULL] && next_st.ctl[b][crb_pkg::CTL_IE]) begin
            next_st.rx_irq = 1'b1;
         end
         if (4'(b) < flen && next_st.ctl[b][crb_pkg::CTL_FULL]) begin
            fifo_used = fifo_used + 4'h1;
         end
      end
      wm_target = next_st.wm ? crb_pkg::WM_ONE_EMPTY : crb_pkg::WM_FOUR_EMPTY;
      next_st.wm_irq = (next_st.mode == crb_pkg::CRB_FIFO) &&
                       (flen - fifo_used == wm_target);
      next_st.awready = !next_st.aw_have;
      next_st.wready = !next_st.w_have;
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign rx_irq = st.rx_irq;
   assign fifo_watermark_irq = st.wm_irq;
   assign rx_timestamp = st.ts_pulse;
endmodule
